// File: logic/dcsf_map.vh
/*
 * Bit positions, reset values and timing counts of control word 0 and
 * status word 0 of the driver. Included by the frame logic by bare name.
 */
`ifndef DCSF_MAP_VH
`define DCSF_MAP_VH

`define DCSF_FRAME_W        24
`define DCSF_BIT_ENABLE     23
`define DCSF_BIT_CLR_STAT   22
`define DCSF_BIT_OC_DUTY    21
`define DCSF_BIT_CM_SEL_HI  19
`define DCSF_BIT_CM_SEL_LO  18
`define DCSF_BIT_NOT_READY  18
`define DCSF_BIT_NO_ERROR   0
// Driver bits 17,15,14,10..1
`define DCSF_DRV_MASK       24'h02c7fe
`define DCSF_CTRL_RESET     24'h000000
// Start-up and retry times in ns
`define DCSF_STARTUP_NS     100000
`define DCSF_RETRY_OFF_NS   20000
`define DCSF_CLK_NS         10
// Current monitor source codes
`define DCSF_CM_HIGHSIDE_OUTPUT_EIGHT        2'h0
`define DCSF_CM_BRIDGE_OUTPUT_ONE        2'h1
`define DCSF_CM_BRIDGE_OUTPUT_FIVE        2'h2
`define DCSF_CM_BRIDGE_OUTPUT_FOUR        2'h3
// Test mux codes
`define DCSF_TM_IREF        3'h0
`define DCSF_TM_TS1         3'h1
`define DCSF_TM_TS2         3'h2
`define DCSF_TM_TS3         3'h3
`define DCSF_TM_TS4         3'h4
`define DCSF_TM_VBG         3'h5
`define DCSF_TM_NONE        3'h7

`endif

// File: logic/dcsf_frame0.v
/*
 * Control word 0 / status word 0 logic of a multi-output driver.
 * Assumes an SPI shifter delivers the written frame with a one-cycle
 * commit strobe at the chip-select rising edge, already in mclk domain,
 * and reads the status frame from a flop output. Analog-side inputs
 * (over-current, PWM pins, test-mode detect) are asynchronous.
 */
// Behaviour
// - Leaving standby starts timer, sets not-ready
// - Not-ready cleared on internal clock timing
// - Driver bits switch their drivers on/off
// - PWM-enabled drivers also need their pulse input
// - Never both drivers of a half bridge
// - Over-current sets flag, disables that driver
// - Recovery retries driver every retry period; bit21 duty drives nothing
// - Test mode routes analog signal by bridge bits
// - Bridge 3..5 code chooses the test source
// - Bit 0 is NOR of flags 1..22 of status word 0 and of status word 1
// - Clear-status bit clears over-current flags at commit
// - Enable bit low is standby, clears controls
`timescale 1ns/10ps
`include "dcsf_map.vh"

module dcsf_frame0 #(
    parameter STARTUP_CYCLES = (`DCSF_STARTUP_NS + `DCSF_CLK_NS - 1) / `DCSF_CLK_NS,
    parameter RETRY_CYCLES   = `DCSF_RETRY_OFF_NS / `DCSF_CLK_NS
) (
    input  wire        mclk,
    input  wire        nrst,
    input  wire [23:0] frame_wdata,
    input  wire        frame_commit,
    input  wire [23:0] pwm_enable,
    input  wire [23:0] pwm_select_second,
    input  wire [23:0] oc_recovery_enable,
    input  wire [22:0] status_one_flags,
    input  wire [23:0] over_current_raw,
    input  wire        pulse_input_first,
    input  wire        pulse_input_second,
    input  wire        test_mode_raw,
    output reg  [23:0] status_rdata,
    output reg  [23:0] driver_on,
    output reg  [1:0]  current_monitor_sel,
    output reg  [2:0]  test_mux_sel,
    output reg         test_mux_active,
    output reg         active_mode
);

    localparam [23:0] DRV_MASK = `DCSF_DRV_MASK;
    localparam [2:0]  ST_STANDBY = 3'h1;
    localparam [2:0]  ST_START   = 3'h2;
    localparam [2:0]  ST_RUN     = 3'h4;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    reg [23:0] oc_s1_q, oc_s2_q;
    reg [1:0]  pwm_s1_q, pwm_s2_q;
    reg        tm_s1_q, tm_s2_q;

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            oc_s1_q  <= 24'h000000;
            oc_s2_q  <= 24'h000000;
            pwm_s1_q <= 2'h0;
            pwm_s2_q <= 2'h0;
            tm_s1_q  <= 1'b0;
            tm_s2_q  <= 1'b0;
        end else begin
            oc_s1_q  <= over_current_raw;
            oc_s2_q  <= oc_s1_q;
            pwm_s1_q <= {pulse_input_second, pulse_input_first};
            pwm_s2_q <= pwm_s1_q;
            tm_s1_q  <= test_mode_raw;
            tm_s2_q  <= tm_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control word and mode sequencer
    reg [23:0] ctrl_q;
    reg [2:0]  state_q;
    reg [16:0] start_cnt_q;
    wire       commit_en  = frame_commit & frame_wdata[`DCSF_BIT_ENABLE];
    wire       commit_clr = frame_commit & frame_wdata[`DCSF_BIT_CLR_STAT];

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q      <= `DCSF_CTRL_RESET;
            state_q     <= ST_STANDBY;
            start_cnt_q <= 17'h00000;
        end else begin
            if (frame_commit)
                ctrl_q <= commit_en ? frame_wdata : `DCSF_CTRL_RESET;
            case (state_q)
                ST_STANDBY: begin
                    if (commit_en) begin
                        state_q     <= ST_START;
                        start_cnt_q <= 17'h00000;
                    end
                end
                ST_START: begin
                    if (frame_commit && !commit_en)
                        state_q <= ST_STANDBY;
                    else if (start_cnt_q == STARTUP_CYCLES[16:0] - 17'h00001)
                        state_q <= ST_RUN;
                    else
                        start_cnt_q <= start_cnt_q + 17'h00001;
                end
                ST_RUN: begin
                    if (frame_commit && !commit_en)
                        state_q <= ST_STANDBY;
                end
                default: state_q <= ST_STANDBY;
            endcase
        end
    end

    wire not_ready = (state_q == ST_START);

    ////////////////////////////////////////////////////////////////////////
    // Over-current latch and retry
    reg [23:0] oc_flag_q;
    reg [14:0] retry_cnt_q;
    reg        retry_on_q;
    wire       retry_wrap = (retry_cnt_q == RETRY_CYCLES[14:0] - 15'h0001);
    // Duty: bit21 set gives a longer on phase; period fixed at RETRY_CYCLES, off phase is the rest
    wire [14:0] on_len = ctrl_q[`DCSF_BIT_OC_DUTY] ? (RETRY_CYCLES[14:0] >> 1)
                                                   : (RETRY_CYCLES[14:0] >> 3);

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            retry_cnt_q <= 15'h0000;
            retry_on_q  <= 1'b0;
        end else begin
            retry_cnt_q <= retry_wrap ? 15'h0000 : retry_cnt_q + 15'h0001;
            if (retry_wrap)
                retry_on_q <= 1'b1;
            else if (retry_cnt_q == on_len)
                retry_on_q <= 1'b0;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 24; gi = gi + 1) begin : g_oc
            if (DRV_MASK[gi]) begin : g_drv
                always @(posedge mclk or negedge nrst) begin
                    if (!nrst)
                        oc_flag_q[gi] <= 1'b0;
                    else if (oc_s2_q[gi] && driver_on[gi])
                        oc_flag_q[gi] <= 1'b1;
                    else if (commit_clr)
                        oc_flag_q[gi] <= 1'b0;
                    else if (oc_recovery_enable[gi] && retry_wrap)
                        oc_flag_q[gi] <= 1'b0;
                end
            end else begin : g_none
                // Spare bit: a constant flop, so status never reads unknown
                always @(posedge mclk or negedge nrst) begin
                    if (!nrst)
                        oc_flag_q[gi] <= 1'b0;
                    else
                        oc_flag_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Driver gating
    reg [23:0] drv_d;
    integer    bi;

    always @* begin
        drv_d = ctrl_q & DRV_MASK;
        for (bi = 0; bi < 24; bi = bi + 1) begin
            if (pwm_enable[bi] && !(pwm_select_second[bi] ? pwm_s2_q[1] : pwm_s2_q[0]))
                drv_d[bi] = 1'b0;
        end
        drv_d = drv_d & ~oc_flag_q;
        // Half bridges: LS at odd bit, HS just above; both set means off
        for (bi = 1; bi < 10; bi = bi + 2) begin
            if (drv_d[bi] && drv_d[bi+1]) begin
                drv_d[bi]   = 1'b0;
                drv_d[bi+1] = 1'b0;
            end
        end
        if (state_q != ST_RUN || tm_s2_q)
            drv_d = 24'h000000;
    end

    ////////////////////////////////////////////////////////////////////////
    // Monitor and test mux selection
    reg [2:0] tm_d;
    always @* begin
        case ({ctrl_q[5], ctrl_q[6], ctrl_q[7], ctrl_q[8], ctrl_q[9], ctrl_q[10]})
            6'h00:   tm_d = `DCSF_TM_IREF;
            6'h30:   tm_d = `DCSF_TM_TS1;
            6'h0c:   tm_d = `DCSF_TM_TS2;
            6'h3c:   tm_d = `DCSF_TM_TS3;
            6'h03:   tm_d = `DCSF_TM_TS4;
            6'h3f:   tm_d = `DCSF_TM_VBG;
            default: tm_d = `DCSF_TM_NONE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Status and outputs
    reg [23:0] stat_d;
    always @* begin
        stat_d = oc_flag_q;
        stat_d[`DCSF_BIT_ENABLE]    = 1'b1;
        stat_d[`DCSF_BIT_NOT_READY] = not_ready;
        stat_d[22:19] = status_one_flags[22:19];
        stat_d[`DCSF_BIT_NO_ERROR] = ~(|stat_d[22:1] | |status_one_flags[22:1]);
    end

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            status_rdata        <= 24'h800001;
            driver_on           <= 24'h000000;
            current_monitor_sel <= `DCSF_CM_HIGHSIDE_OUTPUT_EIGHT;
            test_mux_sel        <= `DCSF_TM_NONE;
            test_mux_active     <= 1'b0;
            active_mode         <= 1'b0;
        end else begin
            status_rdata        <= stat_d;
            driver_on           <= drv_d;
            current_monitor_sel <= {ctrl_q[`DCSF_BIT_CM_SEL_LO],
                                    ctrl_q[`DCSF_BIT_CM_SEL_HI]};
            test_mux_sel        <= tm_s2_q ? tm_d : `DCSF_TM_NONE;
            test_mux_active     <= tm_s2_q;
            active_mode         <= (state_q != ST_STANDBY);
        end
    end

endmodule

// File: verif/dcsf_props.sv
/* Port checks of dcsf_frame0.
   Assumes one clock and the start-up count shortened to 20. */
`timescale 1ns/10ps
module dcsf_props (
    input wire        mclk,
    input wire        nrst,
    input wire [23:0] frame_wdata,
    input wire        frame_commit,
    input wire [23:0] status_rdata,
    input wire [23:0] driver_on,
    input wire [1:0]  current_monitor_sel,
    input wire        active_mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_no_shoot: assert property ((driver_on[9:1] & driver_on[10:2] & 9'h155) == 9'h0)
        else $error("both drivers of a bridge on");
    a_drv_mask: assert property ((driver_on & 24'hfd3801) == 24'h0)
        else $error("driver on at a spare bit");
    a_standby_off: assert property (!active_mode |-> driver_on == 24'h0)
        else $error("driver on in standby");
    a_notready_off: assert property (status_rdata[18] |-> driver_on == 24'h0)
        else $error("driver on before ready");
    a_oc_blocks: assert property ((status_rdata & driver_on & 24'h02c7fe) == 24'h0)
        else $error("driver on with its fault flag");
    a_nor_flag: assert property (|status_rdata[22:1] |-> !status_rdata[0])
        else $error("no-error set with a flag");
    a_cm_select: assert property (frame_commit && frame_wdata[23] |-> ##2
        current_monitor_sel == {$past(frame_wdata[18], 2), $past(frame_wdata[19], 2)})
        else $error("monitor select wrong");
    a_standby_cmd: assert property (frame_commit && !frame_wdata[23] |-> ##2
        !active_mode && driver_on == 24'h0)
        else $error("standby frame ignored");
    a_start_flag: assert property (frame_commit && frame_wdata[23] && !active_mode
        |-> ##2 status_rdata[18])
        else $error("not-ready flag missing");
    a_ready_bound: assert property ($rose(status_rdata[18]) |->
        status_rdata[18] [*8] ##[1:1000] !status_rdata[18])
        else $error("not-ready timing wrong");
endmodule
bind dcsf_frame0 dcsf_props dcsf_props_i (.mclk, .nrst, .frame_wdata, .frame_commit,
    .status_rdata, .driver_on, .current_monitor_sel, .active_mode);

// File: verif/dcsf_host.sv
/* Master side model: sends whole control frames.
   Assumes commit lands as a one-cycle strobe in the mclk domain. */
`timescale 1ns/10ps
module dcsf_host (
    input  wire        mclk,
    output reg  [23:0] frame_wdata,
    output reg         frame_commit
);
    initial begin
        frame_wdata = 24'h0;
        frame_commit = 1'b0;
    end
    task send(input [23:0] w);
        begin
            @(posedge mclk);
            frame_wdata <= w;
            frame_commit <= 1'b1;
            @(posedge mclk);
            // Data invalid outside the frame
            frame_wdata <= ~w;
            frame_commit <= 1'b0;
        end
    endtask
    task clear_fault(input [23:0] w);
        send(w | 24'h400000);
    endtask
endmodule

// File: verif/dcsf_frame0_bench.sv
/* Self-checking bench of dcsf_frame0.
   Assumes shortened start-up and retry counts set below. */
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module dcsf_frame0_bench;
    reg         mclk, nrst, p1, p2, tm;
    reg  [23:0] pen, psel, rec, oc;
    reg  [22:0] s1;
    wire [23:0] wd, st, drv;
    wire        fc, tma, act;
    wire [1:0]  cm;
    wire [2:0]  tmx;
    int         fails, cmp_count, i;
    dcsf_host dcsf_host_i (.mclk(mclk), .frame_wdata(wd), .frame_commit(fc));
    dcsf_frame0 #(.STARTUP_CYCLES(20), .RETRY_CYCLES(16)) dcsf_frame0_i (
        .mclk(mclk), .nrst(nrst), .frame_wdata(wd), .frame_commit(fc),
        .pwm_enable(pen), .pwm_select_second(psel), .oc_recovery_enable(rec),
        .status_one_flags(s1), .over_current_raw(oc), .pulse_input_first(p1),
        .pulse_input_second(p2), .test_mode_raw(tm), .status_rdata(st),
        .driver_on(drv), .current_monitor_sel(cm), .test_mux_sel(tmx),
        .test_mux_active(tma), .active_mode(act));
    task tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task print_verdict;
        begin
            $display("mismatches %0d compares %0d", fails, cmp_count);
            if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        #100000;
        fails++;
        print_verdict;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {nrst, p1, p2, tm, pen, psel, rec, oc, s1} = '0;
        tick(3);
        nrst <= 1'b1;
        tick(2);
        `CHK(st, 24'h800001)
        `CHK({act, drv}, 25'h0)
        dcsf_host_i.send(24'h800004);
        tick(3);
        `CHK({st[18], drv}, 25'h1000000)
        for (i = 0; i < 300 && st[18] !== 1'b0; i++) tick(1);
        tick(3);
        `CHK(drv, 24'h000004)
        for (i = 0; i < 4; i++) begin
            dcsf_host_i.send(24'h82c7fe | {i[0], i[1], 18'h0});
            tick(4);
            `CHK({cm, drv}, {i[1:0], 24'h02c000})
        end
        pen[2] <= 1'b1;
        dcsf_host_i.send(24'h800004);
        tick(5);
        `CHK(drv[2], 1'b0)
        p1 <= 1'b1;
        tick(6);
        `CHK(drv[2], 1'b1)
        psel[2] <= 1'b1;
        tick(6);
        `CHK(drv[2], 1'b0)
        p2 <= 1'b1;
        tick(6);
        `CHK(drv[2], 1'b1)
        pen[2] <= 1'b0;
        oc[2] <= 1'b1;
        tick(8);
        `CHK({st[2], st[0], drv[2]}, 3'b100)
        oc[2] <= 1'b0;
        tick(40);
        `CHK(st[2], 1'b1)
        dcsf_host_i.clear_fault(24'h800004);
        tick(6);
        `CHK({st[2], drv[2]}, 2'b01)
        rec[2] <= 1'b1;
        oc[2] <= 1'b1;
        tick(8);
        oc[2] <= 1'b0;
        `CHK(st[2], 1'b1)
        for (i = 0; i < 40 && st[2] !== 1'b0; i++) tick(1);
        `CHK(st[2], 1'b0)
        s1[5] <= 1'b1;
        tick(5);
        `CHK(st[0], 1'b0)
        s1[5] <= 1'b0;
        tick(5);
        `CHK(st[0], 1'b1)
        tm <= 1'b1;
        for (i = 0; i < 8; i++) begin
            dcsf_host_i.send(24'h800000 | {i[2], i[2], i[1], i[1], i[0], i[0], 5'h0});
            tick(5);
            `CHK({tma, tmx, drv}, {1'b1, (i < 5) ? i[2:0] : (i == 7) ? 3'h5 : 3'h7, 24'h0})
        end
        tm <= 1'b0;
        dcsf_host_i.send(24'h000004);
        tick(4);
        `CHK({act, drv}, 25'h0)
        print_verdict;
    end
endmodule
